// >>> rtl/sam_pins.sv
// memory pin driver with address translation across two clock domains
`timescale 1ns/100ps
module sam_pins
  import sam_pkg::*;
(
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  input  wire logic                            mem_clock,
  input  wire logic                            clock_run,
  input  sam_pkg::sam_cfg_t                    cfg,
  input  wire logic                            req_valid,
  input  sam_pkg::sam_req_t                    req,
  output logic                                 req_ready,
  output logic                                 done,
  output logic      [sam_pkg::DATA_W-1:0]      rdata,
  output logic                                 memory_clock_out,
  output logic                                 memory_clock_enable_out,
  output logic                                 memory_select_n,
  output logic                                 row_strobe_n,
  output logic                                 col_strobe_n,
  output logic                                 write_strobe_n,
  output logic      [sam_pkg::BANK_W-1:0]      bank_select,
  output logic      [sam_pkg::PIN_ADDR_W-1:0]  mem_addr,
  output logic      [sam_pkg::LANES-1:0]       byte_mask_n,
  output logic      [sam_pkg::DATA_W-1:0]      dq_out,
  output logic                                 dq_oe_n,
  input  wire logic [sam_pkg::DATA_W-1:0]      dq_in
);
  import sam_pkg::*;

  typedef enum logic [2:0] {LK_IDLE, LK_ACT, LK_GAP, LK_RW, LK_LAT, LK_PRE, LK_DONE} sam_link_t;

  // ---------------- system clock domain ----------------
  sam_coord_t          coord;
  sam_cmd_t            held_q;
  logic                req_tgl_q;
  logic                ack_seen_q;
  logic                ack_s;
  logic                ready_q;
  logic                done_q;
  logic [DATA_W-1:0]   rdata_q;
  logic [LANES-1:0]    mask_n;
  logic                take;
  logic                ack_new;

  // ---------------- link clock domain ----------------
  sam_link_t           state_q;
  logic                run_s;
  logic                req_s;
  logic                req_seen_q;
  logic                ack_tgl_q;
  logic                clk_out_q;
  logic                cke_q;
  logic                sel_n_q;
  logic                ras_n_q;
  logic                cas_n_q;
  logic                we_n_q;
  logic [BANK_W-1:0]   ba_q;
  logic [PIN_ADDR_W-1:0] a_q;
  logic [LANES-1:0]    mask_n_q;
  logic [DATA_W-1:0]   dq_out_q;
  logic                dq_oe_n_q;
  logic [DATA_W-1:0]   dq_s;
  logic [DATA_W-1:0]   capt_q;
  logic [1:0]          lat_q;
  logic                step;
  logic                pending;

  // address split for the incoming request
  sam_addr_split u_split (
    .addr  (req.addr),
    .cfg   (cfg),
    .coord (coord)
  );

  // byte lanes from enables; upper lanes unused on a half-width bus
  always_comb begin
    mask_n = ~req.byte_en;
    if (cfg.bus16) begin
      mask_n = MASK_HALF | ~req.byte_en;
    end
  end

  assign take    = req_valid && ready_q;
  assign ack_new = (ack_s != ack_seen_q);

  // acknowledge toggle back into the system clock
  sam_sync #(.WIDTH(1)) u_ack_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in (ack_tgl_q),
    .sync_out (ack_s)
  );

  // hold the translated command stable while the link works on it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= '0;
    end else if (take) begin
      held_q.coord  <= coord;
      held_q.write  <= req.write;
      held_q.bus16  <= cfg.bus16;
      held_q.mask_n <= mask_n;
      held_q.wdata  <= req.wdata;
    end
  end

  // request toggle and ready flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_tgl_q <= 1'b0;
      ready_q   <= 1'b1;
    end else if (take) begin
      req_tgl_q <= ~req_tgl_q;
      ready_q   <= 1'b0;
    end else if (ack_new) begin
      ready_q   <= 1'b1;
    end
  end

  // completion pulse and returned read data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_seen_q <= 1'b0;
      done_q     <= 1'b0;
      rdata_q    <= '0;
    end else begin
      done_q <= ack_new;
      if (ack_new) begin
        ack_seen_q <= ack_s;
        rdata_q    <= capt_q; // stable since before the ack toggle
      end
    end
  end

  assign req_ready = ready_q;
  assign done      = done_q;
  assign rdata     = rdata_q;

  // run level and request toggle into the link clock
  sam_sync #(.WIDTH(2)) u_ctl_sync (
    .clock    (mem_clock),
    .rst_n    (rst_n),
    .async_in ({clock_run, req_tgl_q}),
    .sync_out ({run_s, req_s})
  );

  // data pins pass two flops before capture logic reads them
  sam_sync #(.WIDTH(DATA_W)) u_dq_sync (
    .clock    (mem_clock),
    .rst_n    (rst_n),
    .async_in (dq_in),
    .sync_out (dq_s)
  );

  // pins move only in the cycle before the memory clock falls
  assign step    = run_s && clk_out_q;
  assign pending = (req_s != req_seen_q);

  // memory clock divider, parked low until running
  always_ff @(posedge mem_clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_q <= PIN_LOW;
      cke_q     <= PIN_LOW;
    end else begin
      clk_out_q <= run_s ? ~clk_out_q : PIN_LOW;
      cke_q     <= run_s;
    end
  end

  // access sequence: activate, column command, read latency, precharge
  always_ff @(posedge mem_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= LK_IDLE;
      lat_q   <= '0;
    end else if (step) begin
      case (state_q)
        LK_IDLE: begin
          if (pending) begin
            state_q <= LK_ACT;
          end
        end
        LK_ACT: begin
          state_q <= LK_GAP;
        end
        LK_GAP: begin
          state_q <= LK_RW;
        end
        LK_RW: begin
          lat_q   <= CAS_LATENCY;
          state_q <= held_q.write ? LK_PRE : LK_LAT;
        end
        LK_LAT: begin
          lat_q <= lat_q - 2'h1;
          if (lat_q == 2'h1) begin
            state_q <= LK_PRE;
          end
        end
        LK_PRE: begin
          state_q <= LK_DONE;
        end
        LK_DONE: begin
          state_q <= LK_IDLE;
        end
        default: begin
          state_q <= LK_IDLE;
        end
      endcase
    end
  end

  // command pins for the state being entered
  always_ff @(posedge mem_clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_n_q <= PIN_HIGH;
      ras_n_q <= PIN_HIGH;
      cas_n_q <= PIN_HIGH;
      we_n_q  <= PIN_HIGH;
    end else if (step) begin
      sel_n_q <= PIN_HIGH;
      ras_n_q <= PIN_HIGH;
      cas_n_q <= PIN_HIGH;
      we_n_q  <= PIN_HIGH;
      case (state_q)
        LK_IDLE: begin
          if (pending) begin
            sel_n_q <= PIN_LOW;
            ras_n_q <= PIN_LOW;
          end
        end
        LK_GAP: begin
          sel_n_q <= PIN_LOW;
          cas_n_q <= PIN_LOW;
          we_n_q  <= ~held_q.write;
        end
        LK_RW: begin
          if (held_q.write) begin
            sel_n_q <= PIN_LOW; // precharge straight after a write
            ras_n_q <= PIN_LOW;
            we_n_q  <= PIN_LOW;
          end
        end
        LK_LAT: begin
          if (lat_q == 2'h1) begin
            sel_n_q <= PIN_LOW;
            ras_n_q <= PIN_LOW;
            we_n_q  <= PIN_LOW;
          end
        end
        default: begin
          sel_n_q <= PIN_HIGH;
        end
      endcase
    end
  end

  // bank, address and byte mask pins
  always_ff @(posedge mem_clock or negedge rst_n) begin
    if (!rst_n) begin
      ba_q     <= '0;
      a_q      <= '0;
      mask_n_q <= MASK_ALL_OFF;
    end else if (step) begin
      if (state_q == LK_IDLE && pending) begin
        ba_q <= held_q.coord.bank;
        a_q  <= held_q.coord.row;
      end else if (state_q == LK_GAP) begin
        a_q      <= PIN_ADDR_W'(held_q.coord.col);
        mask_n_q <= held_q.mask_n;
      end else if (state_q == LK_RW && held_q.write) begin
        mask_n_q <= MASK_ALL_OFF;
      end else if (state_q == LK_LAT && lat_q == 2'h1) begin
        mask_n_q <= MASK_ALL_OFF;
      end
    end
  end

  // write data drive during the column command
  always_ff @(posedge mem_clock or negedge rst_n) begin
    if (!rst_n) begin
      dq_out_q  <= '0;
      dq_oe_n_q <= PIN_HIGH;
    end else if (step) begin
      if (state_q == LK_GAP && held_q.write) begin
        dq_out_q  <= held_q.wdata;
        dq_oe_n_q <= PIN_LOW;
      end else begin
        dq_oe_n_q <= PIN_HIGH;
      end
    end
  end

  // read capture, half-width bus lands in the low lanes
  always_ff @(posedge mem_clock or negedge rst_n) begin
    if (!rst_n) begin
      capt_q <= '0;
    end else if (step && state_q == LK_LAT && lat_q == 2'h1) begin
      capt_q <= held_q.bus16 ? {16'h0000, dq_s[15:0]} : dq_s;
    end
  end

  // acknowledge toggle once the sequence closes
  always_ff @(posedge mem_clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_tgl_q  <= 1'b0;
      req_seen_q <= 1'b0;
    end else if (step && state_q == LK_DONE) begin
      ack_tgl_q  <= ~ack_tgl_q;
      req_seen_q <= req_s;
    end
  end

  // pins straight from link-domain flops
  assign memory_clock_out        = clk_out_q;
  assign memory_clock_enable_out = cke_q;
  assign memory_select_n         = sel_n_q;
  assign row_strobe_n            = ras_n_q;
  assign col_strobe_n            = cas_n_q;
  assign write_strobe_n          = we_n_q;
  assign bank_select             = ba_q;
  assign mem_addr                = a_q;
  assign byte_mask_n             = mask_n_q;
  assign dq_out                  = dq_out_q;
  assign dq_oe_n                 = dq_oe_n_q;

endmodule : sam_pins

// >>> rtl/sam_pkg.sv
// shared types and constants for the memory address mapper and pin driver
package sam_pkg;

  // system address and memory geometry
  localparam int SYS_ADDR_W   = 28;
  localparam int ROW_W        = 13;
  localparam int COL_W        = 11;
  localparam int BANK_W       = 2;
  localparam int PIN_ADDR_W   = 13;
  localparam int DATA_W       = 32;
  localparam int LANES        = 4;
  localparam int OFFSET_W     = 2;

  // field positions and base widths
  localparam int OFFSET_LSB_WORD = 2;
  localparam int OFFSET_LSB_HALF = 1;
  localparam int COL_BITS_MIN    = 8;
  localparam int ROW_BITS_2K     = 11;
  localparam int ROW_BITS_4K     = 12;
  localparam int ROW_BITS_8K     = 13;

  // read data follows the column command by this many memory clocks
  localparam logic [1:0] CAS_LATENCY = 2'h2;

  // pin levels while idle or under reset, and the half-width lane mask
  localparam logic             PIN_HIGH     = 1'b1;
  localparam logic             PIN_LOW      = 1'b0;
  localparam logic [LANES-1:0] MASK_ALL_OFF = 4'hF;
  localparam logic [LANES-1:0] MASK_HALF    = 4'hC;

  typedef enum logic [1:0] {ROWS_2K, ROWS_4K, ROWS_8K} sam_rows_t;
  typedef enum logic [1:0] {COLS_256, COLS_512, COLS_1024, COLS_2048} sam_cols_t;

  // geometry settings from the system side
  typedef struct packed {
    logic      bus16;
    sam_rows_t rows;
    sam_cols_t cols;
  } sam_cfg_t;

  // one access request as the system presents it
  typedef struct packed {
    logic [SYS_ADDR_W-1:0] addr;
    logic                  write;
    logic [LANES-1:0]      byte_en;
    logic [DATA_W-1:0]     wdata;
  } sam_req_t;

  // an address broken into memory coordinates
  typedef struct packed {
    logic [BANK_W-1:0]   bank;
    logic [ROW_W-1:0]    row;
    logic [COL_W-1:0]    col;
    logic [OFFSET_W-1:0] offset;
  } sam_coord_t;

  // the word held stable across the clock crossing
  typedef struct packed {
    sam_coord_t        coord;
    logic              write;
    logic              bus16;
    logic [LANES-1:0]  mask_n;
    logic [DATA_W-1:0] wdata;
  } sam_cmd_t;

endpackage : sam_pkg

// >>> rtl/sam_sync.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/100ps
module sam_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : sam_sync

// >>> rtl/sam_addr_split.sv
// splits a flat system address into bank, row, column and byte offset
`timescale 1ns/100ps
module sam_addr_split
  import sam_pkg::*;
(
  input  wire logic [sam_pkg::SYS_ADDR_W-1:0] addr,
  input  sam_pkg::sam_cfg_t                   cfg,
  output sam_pkg::sam_coord_t                 coord
);
  int unsigned col_bits;
  int unsigned row_bits;
  int unsigned base;

  // field widths follow the configured geometry
  always_comb begin
    col_bits = COL_BITS_MIN + int'(cfg.cols);
    case (cfg.rows)
      ROWS_2K: row_bits = ROW_BITS_2K;
      ROWS_4K: row_bits = ROW_BITS_4K;
      ROWS_8K: row_bits = ROW_BITS_8K;
      default: row_bits = ROW_BITS_2K;
    endcase
    base = cfg.bus16 ? OFFSET_LSB_HALF : OFFSET_LSB_WORD;
  end

  // column above offset, row above column, bank on top
  always_comb begin
    coord.offset = cfg.bus16 ? {1'b0, addr[0]} : addr[1:0];
    coord.col    = COL_W'((addr >> base) & ((SYS_ADDR_W'(1) << col_bits) - 1'b1));
    coord.row    = ROW_W'((addr >> (base + col_bits)) & ((SYS_ADDR_W'(1) << row_bits) - 1'b1));
    coord.bank   = BANK_W'(addr >> (base + col_bits + row_bits));
  end
endmodule : sam_addr_split

// >>> tb/sam_mem_model.sv
// behavioural synchronous memory at the far side of the pin driver
`timescale 1ns/100ps
module sam_mem_model
  import sam_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sel_n,
  input  wire logic                    ras_n,
  input  wire logic                    cas_n,
  input  wire logic                    we_n,
  input  wire logic [BANK_W-1:0]       ba,
  input  wire logic [PIN_ADDR_W-1:0]   addr,
  input  wire logic [LANES-1:0]        mask_n,
  input  wire logic [DATA_W-1:0]       wd,
  output logic      [DATA_W-1:0]       rd
);
  logic [DATA_W-1:0] mem [logic [25:0]];
  logic [BANK_W-1:0] bank_q;
  logic [ROW_W-1:0]  row_q;
  logic [COL_W-1:0]  col_q;
  logic [LANES-1:0]  mask_q;
  logic [DATA_W-1:0] word_q = '0;
  logic [2:0]        rd_q = '0;

  // word shown from one clock after the column command, inverted when released
  assign rd = (rd_q[1] || rd_q[2]) ? word_q : ~word_q;

  // commands taken on the rising memory clock
  always @(posedge clk) begin
    logic [25:0]       k;
    logic [DATA_W-1:0] w;
    k = {bank_q, row_q, addr[COL_W-1:0]};
    w = mem.exists(k) ? mem[k] : '0;
    rd_q <= {rd_q[1:0], 1'b0};
    // precharge shares row strobe low; only write strobe high marks an activate
    if (!sel_n && !ras_n && cas_n && we_n) begin
      bank_q <= ba;
      row_q  <= addr;
    end
    if (!sel_n && ras_n && !cas_n) begin
      col_q  <= addr[COL_W-1:0];
      mask_q <= mask_n;
      if (we_n) begin
        word_q   <= w;
        rd_q[0]  <= 1'b1;
      end else begin
        for (int i = 0; i < LANES; i++)
          if (!mask_n[i]) w[8*i +: 8] = wd[8*i +: 8];
        mem[k] = w;
      end
    end
  end
endmodule : sam_mem_model

// >>> tb/sam_pins_sva.sv
// concurrent checks on the memory pin driver ports
`timescale 1ns/100ps
module sam_pins_sva
  import sam_pkg::*;
(
  input wire logic         clock,
  input wire logic         rst_n,
  input wire logic         mem_clock,
  input wire logic         clock_run,
  input sam_pkg::sam_cfg_t cfg,
  input wire logic         req_valid,
  input wire logic         req_ready,
  input wire logic         done,
  input wire logic         memory_clock_out,
  input wire logic         memory_clock_enable_out,
  input wire logic         memory_select_n,
  input wire logic         row_strobe_n,
  input wire logic         col_strobe_n,
  input wire logic         write_strobe_n,
  input wire logic [3:0]   byte_mask_n,
  input wire logic         dq_oe_n
);
  // command shapes on the memory pins
  sequence act_s; !memory_select_n && !row_strobe_n && col_strobe_n && write_strobe_n; endsequence
  sequence col_s; !memory_select_n && row_strobe_n && !col_strobe_n; endsequence
  sequence wr_s; !memory_select_n && row_strobe_n && !col_strobe_n && !write_strobe_n; endsequence

  clk_low_a: assert property (@(posedge mem_clock) disable iff (!rst_n)
    !clock_run [*4] |-> !memory_clock_out) else $error("memory clock moved while stopped");
  cke_on_a: assert property (@(posedge mem_clock) disable iff (!rst_n)
    clock_run [*4] |-> memory_clock_enable_out) else $error("clock enable not high");
  sel_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    req_ready |-> memory_select_n && row_strobe_n && col_strobe_n && write_strobe_n) else $error("pins busy when idle");
  mask_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    req_ready |-> byte_mask_n == MASK_ALL_OFF && dq_oe_n) else $error("lanes enabled when idle");
  act_col_a: assert property (@(posedge mem_clock) disable iff (!rst_n)
    act_s |-> ##[1:8] col_s) else $error("no column command after activate");
  wr_drive_a: assert property (@(posedge mem_clock) disable iff (!rst_n)
    wr_s |-> !dq_oe_n) else $error("data not driven on write");
  half_mask_a: assert property (@(posedge mem_clock) disable iff (!rst_n)
    col_s |-> !cfg.bus16 || byte_mask_n[3:2] == 2'h3) else $error("upper lanes used on half bus");
  done_time_a: assert property (@(posedge clock) disable iff (!rst_n)
    req_valid && req_ready && memory_clock_enable_out |-> ##[3:60] done) else $error("access never finished");
  done_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    done |-> req_ready ##1 !done) else $error("done not a single ready pulse");
endmodule : sam_pins_sva

// >>> tb/sam_pins_tb.sv
// self-checking bench for the memory pin driver
`timescale 1ns/100ps
module sam_pins_tb;
  import sam_pkg::*;
  logic                  clock, rst_n, mem_clock, clock_run, req_valid, req_ready, done;
  logic                  memory_clock_out, memory_clock_enable_out, memory_select_n;
  logic                  row_strobe_n, col_strobe_n, write_strobe_n, dq_oe_n;
  logic [BANK_W-1:0]     bank_select;
  logic [PIN_ADDR_W-1:0] mem_addr;
  logic [LANES-1:0]      byte_mask_n;
  logic [DATA_W-1:0]     rdata, dq_out, dq_in;
  sam_cfg_t              cfg;
  sam_req_t              req;
  int                    n_errors, checks;

  sam_pins sam_pins_i (.clock, .rst_n, .mem_clock, .clock_run, .cfg, .req_valid, .req, .req_ready, .done, .rdata,
    .memory_clock_out, .memory_clock_enable_out, .memory_select_n, .row_strobe_n, .col_strobe_n,
    .write_strobe_n, .bank_select, .mem_addr, .byte_mask_n, .dq_out, .dq_oe_n, .dq_in);
  sam_mem_model sam_mem_model_i (.clk(memory_clock_out), .sel_n(memory_select_n), .ras_n(row_strobe_n),
    .cas_n(col_strobe_n), .we_n(write_strobe_n), .ba(bank_select), .addr(mem_addr), .mask_n(byte_mask_n),
    .wd(dq_out), .rd(dq_in));

  // system clock and unrelated link clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    mem_clock = 1'b0;
    #3.7;
    forever #6 mem_clock = ~mem_clock;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // one request presented until taken
  task automatic issue(logic [27:0] a, logic wr, logic [3:0] be, logic [31:0] wd);
    int n;
    @(negedge clock);
    req = '{addr: a, write: wr, byte_en: be, wdata: wd};
    req_valid = 1'b1;
    // ready seen high at a falling edge means the next rising edge takes it
    for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clock);
    check("taken", n < 100, 1);
    @(negedge clock);
    req_valid = 1'b0;
  endtask : issue

  task automatic wait_done(output logic [31:0] rd);
    int n;
    for (n = 0; n < 200 && done !== 1'b1; n++) @(negedge clock);
    check("done", n < 200, 1);
    rd = rdata;
  endtask : wait_done

  // request parked while the memory clock is stopped
  task automatic t_stopped();
    logic [31:0] rd;
    issue(28'h0000010, 1'b0, 4'hF, '0);
    repeat (30) begin
      @(negedge clock);
      check("clock pin", memory_clock_out, 0);
      check("select", memory_select_n, 1);
      check("mask", byte_mask_n, MASK_ALL_OFF);
      check("clock enable", memory_clock_enable_out, 0);
      check("early done", done, 0);
    end
    clock_run = 1'b1;
    wait_done(rd);
    check("clock enable", memory_clock_enable_out, 1);
    check("blank read", rd, 0);
    $display("test stopped done");
  endtask : t_stopped

  // every bus width, row and column setting: fields, lanes and read back
  task automatic t_map();
    logic [31:0] rd, exp, w1, w2;
    logic [27:0] a;
    int          off, cw, rw;
    for (int k = 0; k < 24; k++) begin
      a = 28'hB6D5A5C + k * 28'h0123457;
      off = (k >= 12) ? 1 : 2;
      rw = 11 + (k / 4) % 3;
      cw = 8 + k % 4;
      w1 = 32'hC3A50000 + k;
      w2 = ~w1;
      cfg = '{bus16: k >= 12, rows: sam_rows_t'((k / 4) % 3), cols: sam_cols_t'(k % 4)};
      issue(a, 1'b1, 4'hF, w1);
      wait_done(rd);
      check("bank", sam_mem_model_i.bank_q, (a >> (off + cw + rw)) & 3);
      check("row", sam_mem_model_i.row_q, (a >> (off + cw)) & ((1 << rw) - 1));
      check("column", sam_mem_model_i.col_q, (a >> off) & ((1 << cw) - 1));
      issue(a, 1'b1, 4'h5, w2);
      wait_done(rd);
      check("lanes", sam_mem_model_i.mask_q, off == 1 ? 4'hE : 4'hA);
      issue(a, 1'b0, 4'hF, '0);
      wait_done(rd);
      exp = (w1 & 32'hFF00FF00) | (w2 & 32'h00FF00FF);
      check("read", rd, off == 1 ? exp & 32'hFFFF : exp);
    end
    $display("test map done");
  endtask : t_map

  // main sequence
  initial begin
    rst_n = 1'b0;
    clock_run = 1'b0;
    req_valid = 1'b0;
    cfg = '0;
    req = '0;
    n_errors = 0;
    checks = 0;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    t_stopped();
    t_map();
    stop_test();
  end

  // watchdog: seventy-three accesses of some fifteen cycles, with wide margin
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end
endmodule : sam_pins_tb

bind sam_pins sam_pins_sva sam_pins_sva_i (.clock, .rst_n, .mem_clock, .clock_run, .cfg, .req_valid, .req_ready,
  .done, .memory_clock_out, .memory_clock_enable_out, .memory_select_n, .row_strobe_n, .col_strobe_n,
  .write_strobe_n, .byte_mask_n, .dq_oe_n);
